// *** hw/prcr_params.svh ***
`ifndef PRCR_PARAMS_SVH
`define PRCR_PARAMS_SVH

`define PRCR_CMD_STORE_ALL 8'h15
`define PRCR_CMD_RESTORE_ALL 8'h16
`define PRCR_CMD_ID_STRING 8'hAD
`define PRCR_CMD_REV_STRING 8'hAE
`define PRCR_CMD_SERIAL_A 8'hB0
`define PRCR_CMD_TOOL_WORD 8'hB1
`define PRCR_CMD_SERIAL_B 8'hB2
`define PRCR_CMD_SCRATCH_PER_CHANNEL_COPY 8'hB3
`define PRCR_CMD_SCRATCH_SHARED 8'hB4
`define PRCR_CMD_MFG_INFO 8'hB6
`define PRCR_CMD_NVM_UNLOCK 8'hBD
`define PRCR_CMD_NVM_ERASE 8'hBE
`define PRCR_CMD_NVM_DATA 8'hBF
`define PRCR_CMD_CHAN_CONFIG 8'hD0
`define PRCR_CMD_GLOBAL_CONFIG 8'hD1
`define PRCR_CMD_ALARM_MASK 8'hD2
`define PRCR_CMD_LOOP_COMP 8'hD3
`define PRCR_CMD_MOD_CONFIG 8'hD4
`define PRCR_CMD_EXT_ALARM_RESP 8'hD5
`define PRCR_CMD_OT_RESPONSE 8'hD6
`define PRCR_CMD_PEAK_IOUT 8'hD7
`define PRCR_CMD_FAST_TELEM 8'hD8
`define PRCR_CMD_OFF_THRESH 8'hDA
`define PRCR_CMD_RETRY_DELAY 8'hDB
`define PRCR_CMD_RESTART_DELAY 8'hDC
`define PRCR_CMD_PEAK_VOUT 8'hDD
`define PRCR_CMD_PEAK_VIN 8'hDE
`define PRCR_CMD_PEAK_TEMP 8'hDF
`define PRCR_CMD_PEAK_IIN 8'hE1
`define PRCR_CMD_CLEAR_PEAKS 8'hE3

`define PRCR_RST_WORD_ZERO 16'h0000
`define PRCR_RST_CHAN_BASE 8'h1D
`define PRCR_RST_CHAN_SEQOFF 8'h3D
`define PRCR_RST_GLOBAL 8'h21
`define PRCR_RST_ALARM_MASK 16'h6993
`define PRCR_RST_LOOP_COMP 8'h70
`define PRCR_RST_MOD_CONFIG 8'hC1
`define PRCR_RST_EXT_RESP 8'hC0
`define PRCR_OT_RESPONSE 8'hC0
`define PRCR_RST_FAST_TELEM 8'h00
`define PRCR_RST_OFF_THRESH 16'h019A
`define PRCR_RST_RETRY 16'hFABC
`define PRCR_RST_RESTART 16'hFBE8

`define PRCR_L11_FLOOR 16'h7C00
`define PRCR_L16_FLOOR 16'h0000
`define PRCR_L11_EXP_MSB 15
`define PRCR_L11_EXP_LSB 11
`define PRCR_L11_MAN_MSB 10
`define PRCR_KEY_FRAC 16
`define PRCR_SUBTICK_LOG2 4

`define PRCR_CLK_HZ 25000000
`define PRCR_MS_PER_S 1000
`define PRCR_STR_BYTES 8
`define PRCR_ID_LEN 8'h08
`define PRCR_REV_LEN 8'h04

`endif

// *** hw/prcr_pkg.sv ***
package prcr_pkg;

    typedef struct packed {
        logic [15:0] userScratch;
        logic [15:0] toolWord;
        logic [7:0] channelConfig;
        logic [15:0] alarmMask;
        logic [7:0] loopComp;
        logic [7:0] modulatorConfig;
        logic [7:0] extAlarmResponse;
        logic [15:0] offThreshold;
        logic [15:0] retryInterval;
        logic [15:0] restartDelay;
    } prcr_chan_cfg_t;

    typedef struct packed {
        logic [15:0] serialA;
        logic [15:0] serialB;
        logic [15:0] userScratch;
        logic [7:0] globalConfig;
    } prcr_shared_cfg_t;

    typedef struct packed {
        logic valid;
        logic [1:0][15:0] outCurrent;
        logic [1:0][15:0] outVoltage;
        logic [1:0][15:0] extTemp;
        logic [15:0] inVoltage;
        logic [15:0] inCurrent;
    } prcr_meas_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic page;
        logic [7:0] code;
        logic [4:0] byteIdx;
        logic [15:0] wdata;
    } prcr_cmd_t;

    typedef enum logic [1:0] {
        PRCR_TMR_IDLE = 2'b00,
        PRCR_TMR_RUN = 2'b01
    } prcr_tmr_state_t;

endpackage

// *** hw/prcr_regs.sv ***
`include "prcr_params.svh"

// What this block does
// - Per-channel peak output current, read-only.
// - Per-channel peak output voltage, unsigned linear.
// - Shared peak input voltage, read-only.
// - Per-channel peak external temperature, read-only.
// - Shared peak input current, read-only.
// - Modulator stays on at or above off threshold; the base variant never keeps it on.
// - Wait retry interval between restart attempts.
// - Hold rail enable low for restart delay.
// - Mask word selects faults pulling alarm low.
// - Response byte for external alarm assertion.
// - Over-temperature response reads fixed value.
// - Fast telemetry select, resets zero, volatile.
// - Two user words, stored, default zero.
// - Channel config default depends on variant.
// - Loop compensation byte, stored, default 0x70.
// - Modulator config byte, stored, default 0xC1.
// - Identity and revision returned as strings; the base variant refuses both.
// - Eleven-bit linear: exponent and mantissa fields.
// - Sixteen-bit linear: unsigned, exponent minus twelve.
// - Clear-peaks command resets every peak tracker.
// - Store-all saves, restore-all reloads stored registers.
module prcr_regs #(
    parameter bit SEQ_OFF_VARIANT = 1'b1,
    parameter int CYCLES_PER_MS = `PRCR_CLK_HZ / `PRCR_MS_PER_S,
    // Identity strings and info word are arbitrary neutral values.
    parameter logic [8*`PRCR_STR_BYTES-1:0] ID_TEXT = "PRC-0001",
    parameter logic [8*`PRCR_STR_BYTES-1:0] REV_TEXT = "R000    ",
    parameter logic [15:0] MFG_INFO_VALUE = 16'h0000
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input prcr_pkg::prcr_cmd_t cmd,
    output logic [15:0] rdData,
    output logic rdAck,
    output logic cmdReject,
    input prcr_pkg::prcr_meas_t meas,
    input wire logic [1:0] seqOffActive,
    output logic [1:0] modulatorActive,
    input wire logic [1:0] retryRequest,
    output logic [1:0] retryGo,
    input wire logic [1:0] railOffRequest,
    output logic [1:0] railHoldLow,
    input wire logic [1:0][15:0] faultFlags,
    input wire logic alarmIn,
    output logic alarmOut,
    output logic alarmOe,
    output logic [1:0] extAlarmActive,
    output prcr_pkg::prcr_chan_cfg_t chanCfg [2],
    output prcr_pkg::prcr_shared_cfg_t sharedCfg,
    output logic [7:0] fastTelemetrySel
);

    localparam int SUBTICK_CYCLES = (CYCLES_PER_MS >> `PRCR_SUBTICK_LOG2) > 0 ?
        (CYCLES_PER_MS >> `PRCR_SUBTICK_LOG2) : 1;

    // Converts an eleven-bit linear word to a signed fixed-point key for ordering.
    function automatic logic signed [47:0] l11Key(input logic [15:0] w);
        logic signed [4:0] e;
        logic signed [47:0] m;
        logic [5:0] sh;
        e = signed'(w[`PRCR_L11_EXP_MSB:`PRCR_L11_EXP_LSB]);
        m = 48'(signed'(w[`PRCR_L11_MAN_MSB:0]));
        sh = 6'(7'(signed'(e)) + 7'(`PRCR_KEY_FRAC));
        l11Key = m <<< sh;
    endfunction

    // Milliseconds in linear form to sixteenth-of-a-millisecond counts.
    // Negative times clamp to zero; sub-tick fractions are dropped.
    function automatic logic [31:0] l11Ticks(input logic [15:0] w);
        logic signed [4:0] e;
        logic signed [10:0] m;
        logic signed [6:0] s;
        e = signed'(w[`PRCR_L11_EXP_MSB:`PRCR_L11_EXP_LSB]);
        m = signed'(w[`PRCR_L11_MAN_MSB:0]);
        s = 7'(e) + 7'(`PRCR_SUBTICK_LOG2);
        if (m[10]) begin
            l11Ticks = 32'h0000_0000;
        end else if (s >= 0) begin
            l11Ticks = 32'(m) << s;
        end else begin
            l11Ticks = 32'(m) >> (-s);
        end
    endfunction

    function automatic prcr_pkg::prcr_chan_cfg_t chanDefault();
        prcr_pkg::prcr_chan_cfg_t c;
        c.userScratch = `PRCR_RST_WORD_ZERO;
        c.toolWord = `PRCR_RST_WORD_ZERO;
        c.channelConfig = SEQ_OFF_VARIANT ? `PRCR_RST_CHAN_SEQOFF : `PRCR_RST_CHAN_BASE;
        c.alarmMask = `PRCR_RST_ALARM_MASK;
        c.loopComp = `PRCR_RST_LOOP_COMP;
        c.modulatorConfig = `PRCR_RST_MOD_CONFIG;
        c.extAlarmResponse = `PRCR_RST_EXT_RESP;
        c.offThreshold = `PRCR_RST_OFF_THRESH;
        c.retryInterval = `PRCR_RST_RETRY;
        c.restartDelay = `PRCR_RST_RESTART;
        chanDefault = c;
    endfunction

    function automatic prcr_pkg::prcr_shared_cfg_t sharedDefault();
        prcr_pkg::prcr_shared_cfg_t s;
        s.serialA = `PRCR_RST_WORD_ZERO;
        s.serialB = `PRCR_RST_WORD_ZERO;
        s.userScratch = `PRCR_RST_WORD_ZERO;
        s.globalConfig = `PRCR_RST_GLOBAL;
        sharedDefault = s;
    endfunction

    function automatic logic [7:0] strByte(input logic [8*`PRCR_STR_BYTES-1:0] t,
                                           input logic [7:0] len,
                                           input logic [4:0] idx);
        if (idx == 5'h00) begin
            strByte = len;
        end else if (8'(idx) <= len) begin
            strByte = t[8*`PRCR_STR_BYTES-8*int'(idx) +: 8];
        end else begin
            strByte = 8'h00;
        end
    endfunction

    prcr_pkg::prcr_chan_cfg_t chanCfg_reg [2];
    prcr_pkg::prcr_chan_cfg_t chanNv_reg [2];
    prcr_pkg::prcr_shared_cfg_t shared_reg;
    prcr_pkg::prcr_shared_cfg_t sharedNv_reg;
    logic [7:0] fastSel_reg;
    logic [1:0][15:0] peakIout_reg;
    logic [1:0][15:0] peakVout_reg;
    logic [1:0][15:0] peakTemp_reg;
    logic [15:0] peakVin_reg;
    logic [15:0] peakIin_reg;
    logic [15:0] rdData_next;
    logic rdKnown;
    logic isWrite;
    logic isRead;
    logic clearPeaks;
    logic storeAll;
    logic restoreAll;
    logic pg;

    assign isWrite = cmd.valid && cmd.write;
    assign isRead = cmd.valid && !cmd.write;
    assign pg = cmd.page;
    assign clearPeaks = isWrite && cmd.code == `PRCR_CMD_CLEAR_PEAKS;
    assign storeAll = isWrite && cmd.code == `PRCR_CMD_STORE_ALL;
    assign restoreAll = isWrite && cmd.code == `PRCR_CMD_RESTORE_ALL;

    // Per_channel_copy writes land only in the copy that the page field selects.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chanCfg_reg[0] <= chanDefault();
            chanCfg_reg[1] <= chanDefault();
            shared_reg <= sharedDefault();
        end else if (restoreAll) begin
            chanCfg_reg <= chanNv_reg;
            shared_reg <= sharedNv_reg;
        end else if (isWrite) begin
            unique case (cmd.code)
                `PRCR_CMD_SERIAL_A: shared_reg.serialA <= cmd.wdata;
                `PRCR_CMD_TOOL_WORD: chanCfg_reg[pg].toolWord <= cmd.wdata;
                `PRCR_CMD_SERIAL_B: shared_reg.serialB <= cmd.wdata;
                `PRCR_CMD_SCRATCH_PER_CHANNEL_COPY: chanCfg_reg[pg].userScratch <= cmd.wdata;
                `PRCR_CMD_SCRATCH_SHARED: shared_reg.userScratch <= cmd.wdata;
                `PRCR_CMD_CHAN_CONFIG: chanCfg_reg[pg].channelConfig <= cmd.wdata[7:0];
                `PRCR_CMD_GLOBAL_CONFIG: shared_reg.globalConfig <= cmd.wdata[7:0];
                `PRCR_CMD_ALARM_MASK: chanCfg_reg[pg].alarmMask <= cmd.wdata;
                `PRCR_CMD_LOOP_COMP: chanCfg_reg[pg].loopComp <= cmd.wdata[7:0];
                `PRCR_CMD_MOD_CONFIG: chanCfg_reg[pg].modulatorConfig <= cmd.wdata[7:0];
                `PRCR_CMD_EXT_ALARM_RESP: chanCfg_reg[pg].extAlarmResponse <= cmd.wdata[7:0];
                `PRCR_CMD_OFF_THRESH: chanCfg_reg[pg].offThreshold <= cmd.wdata;
                `PRCR_CMD_RETRY_DELAY: chanCfg_reg[pg].retryInterval <= cmd.wdata;
                `PRCR_CMD_RESTART_DELAY: chanCfg_reg[pg].restartDelay <= cmd.wdata;
                default: ; // Read-only, factory and unknown codes change nothing.
            endcase
        end
    end

    // The stored image stands in for the nonvolatile array; it loads defaults at reset.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chanNv_reg[0] <= chanDefault();
            chanNv_reg[1] <= chanDefault();
            sharedNv_reg <= sharedDefault();
        end else if (storeAll) begin
            chanNv_reg <= chanCfg_reg;
            sharedNv_reg <= shared_reg;
        end
    end

    // Not part of the stored image, so restore leaves it alone.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fastSel_reg <= `PRCR_RST_FAST_TELEM;
        end else if (isWrite && cmd.code == `PRCR_CMD_FAST_TELEM) begin
            fastSel_reg <= cmd.wdata[7:0];
        end
    end

    // A sample in the clearing cycle seeds the tracker, so no event is lost.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            peakIout_reg <= {2{`PRCR_L11_FLOOR}};
            peakVout_reg <= {2{`PRCR_L16_FLOOR}};
            peakTemp_reg <= {2{`PRCR_L11_FLOOR}};
            peakVin_reg <= `PRCR_L11_FLOOR;
            peakIin_reg <= `PRCR_L11_FLOOR;
        end else if (clearPeaks) begin
            for (int c = 0; c < 2; c++) begin
                peakIout_reg[c] <= meas.valid ? meas.outCurrent[c] : `PRCR_L11_FLOOR;
                peakVout_reg[c] <= meas.valid ? meas.outVoltage[c] : `PRCR_L16_FLOOR;
                peakTemp_reg[c] <= meas.valid ? meas.extTemp[c] : `PRCR_L11_FLOOR;
            end
            peakVin_reg <= meas.valid ? meas.inVoltage : `PRCR_L11_FLOOR;
            peakIin_reg <= meas.valid ? meas.inCurrent : `PRCR_L11_FLOOR;
        end else if (meas.valid) begin
            for (int c = 0; c < 2; c++) begin
                if (l11Key(meas.outCurrent[c]) > l11Key(peakIout_reg[c])) begin
                    peakIout_reg[c] <= meas.outCurrent[c];
                end
                if (meas.outVoltage[c] > peakVout_reg[c]) begin
                    peakVout_reg[c] <= meas.outVoltage[c];
                end
                if (l11Key(meas.extTemp[c]) > l11Key(peakTemp_reg[c])) begin
                    peakTemp_reg[c] <= meas.extTemp[c];
                end
            end
            if (l11Key(meas.inVoltage) > l11Key(peakVin_reg)) begin
                peakVin_reg <= meas.inVoltage;
            end
            if (l11Key(meas.inCurrent) > l11Key(peakIin_reg)) begin
                peakIin_reg <= meas.inCurrent;
            end
        end
    end

    always_comb begin
        rdData_next = 16'h0000;
        rdKnown = 1'b1;
        unique case (cmd.code)
            `PRCR_CMD_ID_STRING: begin
                rdData_next = {8'h00, strByte(ID_TEXT, `PRCR_ID_LEN, cmd.byteIdx)};
                rdKnown = SEQ_OFF_VARIANT;
            end
            `PRCR_CMD_REV_STRING: begin
                rdData_next = {8'h00, strByte(REV_TEXT, `PRCR_REV_LEN, cmd.byteIdx)};
                rdKnown = SEQ_OFF_VARIANT;
            end
            `PRCR_CMD_SERIAL_A: rdData_next = shared_reg.serialA;
            `PRCR_CMD_TOOL_WORD: rdData_next = chanCfg_reg[pg].toolWord;
            `PRCR_CMD_SERIAL_B: rdData_next = shared_reg.serialB;
            `PRCR_CMD_SCRATCH_PER_CHANNEL_COPY: rdData_next = chanCfg_reg[pg].userScratch;
            `PRCR_CMD_SCRATCH_SHARED: rdData_next = shared_reg.userScratch;
            `PRCR_CMD_MFG_INFO: rdData_next = MFG_INFO_VALUE;
            `PRCR_CMD_CHAN_CONFIG: rdData_next = {8'h00, chanCfg_reg[pg].channelConfig};
            `PRCR_CMD_GLOBAL_CONFIG: rdData_next = {8'h00, shared_reg.globalConfig};
            `PRCR_CMD_ALARM_MASK: rdData_next = chanCfg_reg[pg].alarmMask;
            `PRCR_CMD_LOOP_COMP: rdData_next = {8'h00, chanCfg_reg[pg].loopComp};
            `PRCR_CMD_MOD_CONFIG: rdData_next = {8'h00, chanCfg_reg[pg].modulatorConfig};
            `PRCR_CMD_EXT_ALARM_RESP: rdData_next = {8'h00, chanCfg_reg[pg].extAlarmResponse};
            `PRCR_CMD_OT_RESPONSE: rdData_next = {8'h00, `PRCR_OT_RESPONSE};
            `PRCR_CMD_PEAK_IOUT: rdData_next = peakIout_reg[pg];
            `PRCR_CMD_FAST_TELEM: rdData_next = {8'h00, fastSel_reg};
            `PRCR_CMD_OFF_THRESH: rdData_next = chanCfg_reg[pg].offThreshold;
            `PRCR_CMD_RETRY_DELAY: rdData_next = chanCfg_reg[pg].retryInterval;
            `PRCR_CMD_RESTART_DELAY: rdData_next = chanCfg_reg[pg].restartDelay;
            `PRCR_CMD_PEAK_VOUT: rdData_next = peakVout_reg[pg];
            `PRCR_CMD_PEAK_VIN: rdData_next = peakVin_reg;
            `PRCR_CMD_PEAK_TEMP: rdData_next = peakTemp_reg[pg];
            `PRCR_CMD_PEAK_IIN: rdData_next = peakIin_reg;
            default: rdKnown = 1'b0; // Factory codes are refused and leave rdData unchanged.
        endcase
    end

    // Writes to read-only, factory or unknown codes are refused, like unknown reads.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdData <= 16'h0000;
            rdAck <= 1'b0;
            cmdReject <= 1'b0;
        end else begin
            rdAck <= isRead && rdKnown;
            rdData <= (isRead && rdKnown) ? rdData_next : rdData;
            cmdReject <= (isRead && !rdKnown) ||
                (isWrite && !(clearPeaks || storeAll || restoreAll ||
                 cmd.code inside {`PRCR_CMD_SERIAL_A, `PRCR_CMD_TOOL_WORD,
                 `PRCR_CMD_SERIAL_B, `PRCR_CMD_SCRATCH_PER_CHANNEL_COPY, `PRCR_CMD_SCRATCH_SHARED,
                 `PRCR_CMD_CHAN_CONFIG, `PRCR_CMD_GLOBAL_CONFIG, `PRCR_CMD_ALARM_MASK,
                 `PRCR_CMD_LOOP_COMP, `PRCR_CMD_MOD_CONFIG, `PRCR_CMD_EXT_ALARM_RESP,
                 `PRCR_CMD_FAST_TELEM, `PRCR_CMD_OFF_THRESH, `PRCR_CMD_RETRY_DELAY,
                 `PRCR_CMD_RESTART_DELAY}));
        end
    end

    // Shared sub-millisecond tick keeps both timers on one prescaler.
    logic [31:0] subCount_reg;
    logic subTick;
    assign subTick = subCount_reg == 32'(SUBTICK_CYCLES - 1);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            subCount_reg <= 32'h0000_0000;
        end else begin
            subCount_reg <= subTick ? 32'h0000_0000 : subCount_reg + 32'h0000_0001;
        end
    end

    // Timers may end up to one tick early or one cycle late; neither interval is a minimum.
    prcr_pkg::prcr_tmr_state_t retryState_reg [2];
    prcr_pkg::prcr_tmr_state_t holdState_reg [2];
    logic [1:0][31:0] retryCount_reg;
    logic [1:0][31:0] holdCount_reg;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                retryState_reg[c] <= prcr_pkg::PRCR_TMR_IDLE;
                retryCount_reg[c] <= 32'h0000_0000;
                retryGo[c] <= 1'b0;
            end else begin
                retryGo[c] <= 1'b0;
                unique case (retryState_reg[c])
                    prcr_pkg::PRCR_TMR_IDLE: begin
                        if (retryRequest[c]) begin
                            retryCount_reg[c] <= l11Ticks(chanCfg_reg[c].retryInterval);
                            retryState_reg[c] <= prcr_pkg::PRCR_TMR_RUN;
                        end
                    end
                    prcr_pkg::PRCR_TMR_RUN: begin
                        if (retryCount_reg[c] == 32'h0000_0000) begin
                            retryGo[c] <= 1'b1;
                            retryState_reg[c] <= prcr_pkg::PRCR_TMR_IDLE;
                        end else if (subTick) begin
                            retryCount_reg[c] <= retryCount_reg[c] - 32'h0000_0001;
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                holdState_reg[c] <= prcr_pkg::PRCR_TMR_IDLE;
                holdCount_reg[c] <= 32'h0000_0000;
                railHoldLow[c] <= 1'b0;
            end else begin
                unique case (holdState_reg[c])
                    prcr_pkg::PRCR_TMR_IDLE: begin
                        if (railOffRequest[c]) begin
                            holdCount_reg[c] <= l11Ticks(chanCfg_reg[c].restartDelay);
                            holdState_reg[c] <= prcr_pkg::PRCR_TMR_RUN;
                            railHoldLow[c] <= 1'b1;
                        end
                    end
                    prcr_pkg::PRCR_TMR_RUN: begin
                        if (holdCount_reg[c] == 32'h0000_0000) begin
                            railHoldLow[c] <= 1'b0;
                            holdState_reg[c] <= prcr_pkg::PRCR_TMR_IDLE;
                        end else if (subTick) begin
                            holdCount_reg[c] <= holdCount_reg[c] - 32'h0000_0001;
                        end
                    end
                endcase
            end
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                modulatorActive[c] <= 1'b0;
            end else begin
                modulatorActive[c] <= seqOffActive[c] && SEQ_OFF_VARIANT &&
                    meas.outVoltage[c] >= chanCfg_reg[c].offThreshold;
            end
        end

        // Only an outside pull counts, never our own drive of the line.
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                extAlarmActive[c] <= 1'b0;
            end else begin
                extAlarmActive[c] <= !alarmIn && !alarmOe &&
                    chanCfg_reg[c].extAlarmResponse != 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alarmOe <= 1'b0;
        end else begin
            alarmOe <= |(faultFlags[0] & chanCfg_reg[0].alarmMask) ||
                |(faultFlags[1] & chanCfg_reg[1].alarmMask);
        end
    end

    assign alarmOut = 1'b0;
    assign chanCfg = chanCfg_reg;
    assign sharedCfg = shared_reg;
    assign fastTelemetrySel = fastSel_reg;

endmodule

// *** sim/prcr_host.sv ***
module prcr_host (
    input wire logic core_clk,
    input wire logic rdAck,
    input wire logic cmdReject,
    input wire logic [15:0] rdData,
    output prcr_pkg::prcr_cmd_t cmd
);
    timeunit 1ns / 1ps;
    initial cmd = '0;
    task automatic xfer(input logic w, input logic p, input logic [7:0] c, input logic [4:0] i,
        input logic [15:0] d, output logic ak, output logic rj, output logic [15:0] q);
        @(negedge core_clk);
        cmd <= '{1'b1, w, p, c, i, d};
        @(negedge core_clk);
        ak = rdAck;
        rj = cmdReject;
        q = rdData;
        // Idle fields are inverted so no stale value can pass for a request.
        cmd <= '{1'b0, ~w, ~p, ~c, ~i, ~d};
    endtask
endmodule

// *** sim/prcr_regs_checker.sv ***
module prcr_regs_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input prcr_pkg::prcr_cmd_t cmd,
    input logic [15:0] rdData,
    input logic rdAck,
    input logic cmdReject,
    input wire logic [1:0][15:0] faultFlags,
    input logic alarmOe,
    input logic [1:0] railHoldLow,
    input logic [1:0] retryGo,
    input prcr_pkg::prcr_chan_cfg_t chanCfg [2]
);
    timeunit 1ns / 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire almNow = |(faultFlags[0] & chanCfg[0].alarmMask) ||
        |(faultFlags[1] & chanCfg[1].alarmMask);
    property p_ack; cmd.valid && !cmd.write && cmd.code == 8'hD2
        |=> rdAck && !cmdReject; endproperty
    property p_ro; cmd.valid && cmd.write && cmd.code == 8'hD6 |=> cmdReject && !rdAck; endproperty
    property p_fac; cmd.valid && cmd.code inside {[8'hBD:8'hBF]} |=> cmdReject && $stable(rdData);
    endproperty
    property p_alm; 1 |=> alarmOe == $past(almNow); endproperty
    property p_hold; $rose(railHoldLow[0]) |-> railHoldLow[0] [*8]; endproperty
    property p_go; retryGo[0] |=> !retryGo[0]; endproperty
    property p_def; $rose(rst_n) |-> chanCfg[1].retryInterval == 16'hFABC
        && chanCfg[1].restartDelay == 16'hFBE8; endproperty
    property p_wr; cmd.valid && cmd.write && !cmd.page && cmd.code == 8'hD3
        |=> chanCfg[0].loopComp == $past(cmd.wdata[7:0]); endproperty
    a_ack: assert property (p_ack) else $error("read not acked");
    a_ro: assert property (p_ro) else $error("read-only write taken");
    a_fac: assert property (p_fac) else $error("factory code taken");
    a_alm: assert property (p_alm) else $error("alarm drive wrong");
    a_hold: assert property (p_hold) else $error("enable hold too short");
    a_go: assert property (p_go) else $error("retry pulse too long");
    a_def: assert property (p_def) else $error("delay defaults wrong");
    a_wr: assert property (p_wr) else $error("per_channel_copy write wrong");
    c_ack: cover property (rdAck);
    c_hold: cover property ($rose(railHoldLow[0]));
    c_go: cover property (retryGo[0]);
endmodule
bind prcr_regs prcr_regs_checker u_chk (.*);

// *** sim/prcr_regs_tb.sv ***
module prcr_regs_tb;
    timeunit 1ns / 1ps;
    typedef struct packed {logic [3:0] f; logic [7:0] c; logic [15:0] d;
        logic [15:0] q;} prcr_row_t;
    logic core_clk = 1'b0, rst_n = 1'b0, extPull = 1'b0, ak, rj, rdAck, cmdReject;
    logic alarmOut, alarmOe, baseAk, baseRj;
    logic [1:0] seqOffActive = 2'h0, retryRequest = 2'h0, railOffRequest = 2'h0;
    logic [1:0] modulatorActive, retryGo, railHoldLow, extAlarmActive;
    logic [1:0][15:0] faultFlags = '0;
    logic [15:0] q, rdData, baseQ;
    logic [7:0] fastTelemetrySel;
    logic [7:0] pk [4] = '{8'hD7, 8'hDE, 8'hDF, 8'hE1};
    prcr_pkg::prcr_cmd_t cmd;
    prcr_pkg::prcr_meas_t meas = '0;
    prcr_pkg::prcr_shared_cfg_t sharedCfg;
    int failures = 0, cmpCount = 0, n;
    // The shared alarm wire is low while either side pulls it.
    wire alarmIn = !(alarmOe || extPull);
    prcr_row_t rows [17] = '{
        '{4'h6, 8'hD2, 16'h0, 16'h6993},
        '{4'h2, 8'hD6, 16'h0, 16'h00C0},
        '{4'h2, 8'hD8, 16'h0, 16'h0000},
        '{4'h2, 8'hDA, 16'h0, 16'h019A},
        '{4'h2, 8'hD7, 16'h0, 16'h7C00},
        '{4'h9, 8'hD6, 16'h55, 16'h0},
        '{4'h9, 8'hBF, 16'h55, 16'h0},
        '{4'hC, 8'hB3, 16'h1234, 16'h0},
        '{4'h2, 8'hB3, 16'h0, 16'h0000},
        '{4'h6, 8'hB3, 16'h0, 16'h1234},
        '{4'h2, 8'hD3, 16'h0, 16'h0070},
        '{4'h8, 8'hD3, 16'h42, 16'h0},
        '{4'h8, 8'hB4, 16'hAB, 16'h0},
        '{4'h6, 8'hB4, 16'h0, 16'h00AB},
        '{4'h2, 8'hD0, 16'h0, 16'h003D},
        '{4'h2, 8'hAD, 16'h0, 16'h0008},
        '{4'h2, 8'hAE, 16'h0, 16'h0004}};
    prcr_regs #(.CYCLES_PER_MS(32)) uut (.*, .chanCfg());
    prcr_regs #(.SEQ_OFF_VARIANT(1'b0), .CYCLES_PER_MS(32)) uutBase (.*, .rdData(baseQ),
        .rdAck(baseAk), .cmdReject(baseRj), .modulatorActive(), .retryGo(), .railHoldLow(),
        .alarmOut(), .alarmOe(), .extAlarmActive(), .chanCfg(), .sharedCfg(),
        .fastTelemetrySel());
    prcr_host host (.*);
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
        cmpCount++;
        if (v !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d failures %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic op(input logic [3:0] f, input logic [7:0] c, input logic [15:0] d);
        host.xfer(f[3], f[2], c, d[4:0], d, ak, rj, q);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        op(4'h0, c, 16'h0);
        chk("data", e, q);
    endtask
    task automatic smp(input logic [15:0] a, input logic [15:0] v);
        @(negedge core_clk);
        meas <= '{1'b1, {a, a}, {v, v}, {a, a}, a, a};
        @(negedge core_clk);
        meas.valid <= 1'b0;
    endtask
    // A 1 ms setting gives 16 ticks of 2 cycles, plus at most one tick of phase slack.
    task automatic span(input logic rt);
        retryRequest = {1'b0, rt};
        railOffRequest = {1'b0, !rt};
        @(negedge core_clk);
        retryRequest = 2'h0;
        railOffRequest = 2'h0;
        for (n = 0; (rt ? !retryGo[0] : railHoldLow[0]) && n < 200; n++) @(negedge core_clk);
        chk("span", 16'h1, {15'h0, n >= 32 && n <= 35});
        if (n == 200) end_sim();
    endtask
    initial forever #20 core_clk = ~core_clk;
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        end_sim();
    end
    initial begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        foreach (rows[k]) begin
            op(rows[k].f, rows[k].c, rows[k].d);
            chk("ack", {15'h0, rows[k].f[1]}, {15'h0, ak});
            chk("reject", {15'h0, rows[k].f[0]}, {15'h0, rj});
            if (rows[k].f[1]) chk("data", rows[k].q, q);
        end
        chk("baseData", 16'h001D, baseQ);
        chk("baseReject", 16'h1, {15'h0, baseRj});
        chk("sharedScratch", 16'h00AB, sharedCfg.userScratch);
        seqOffActive = 2'h1;
        smp(16'h0005, 16'h1000);
        smp(16'hF804, 16'h0800);
        chk("modActive", 16'h1, {14'h0, modulatorActive});
        foreach (pk[k]) rd(pk[k], 16'h0005);
        rd(8'hDD, 16'h1000);
        smp(16'h0005, 16'h0100);
        @(negedge core_clk);
        chk("modActive", 16'h0, {14'h0, modulatorActive});
        op(4'h8, 8'hE3, 16'h0);
        rd(8'hD7, 16'h7C00);
        rd(8'hDD, 16'h0000);
        op(4'h8, 8'hD4, 16'h0011);
        op(4'h8, 8'h15, 16'h0);
        op(4'h8, 8'hD4, 16'h0022);
        op(4'h8, 8'hD8, 16'h0007);
        op(4'h8, 8'h16, 16'h0);
        rd(8'hD4, 16'h0011);
        chk("fastSel", 16'h0007, {8'h00, fastTelemetrySel});
        op(4'h8, 8'hDC, 16'h0001);
        span(1'b0);
        op(4'h8, 8'hDB, 16'h0001);
        span(1'b1);
        faultFlags = {16'h0, 16'h0001};
        repeat (2) @(negedge core_clk);
        chk("alarmOe", 16'h2, {14'h0, alarmOe, alarmOut});
        faultFlags = {16'h0, 16'h0004};
        extPull = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("alarmOe", 16'h0, {15'h0, alarmOe});
        chk("extAlarm", 16'h3, {14'h0, extAlarmActive});
        rst_n = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        rd(8'hD4, 16'h00C1);
        end_sim();
    end
endmodule
